// [design/ecb_regs.svh]
// constants for the expansion channel bus control
`ifndef ECB_REGS_SVH
`define ECB_REGS_SVH
`define ECB_CHK_MIN_CYC 2
`define ECB_RDY_MAX_CYC 17
`define ECB_MASTER_MAX_NS 15000
`define ECB_CLK_NS 10
`define ECB_MASTER_MAX_CYC (`ECB_MASTER_MAX_NS / `ECB_CLK_NS)
`define ECB_BASE_WAIT 3
`define ECB_WIDE_WAIT 1
`define ECB_NOWAIT_DELAY 1
`define ECB_LOWMEG_BIT 20
`define ECB_ADDR_W 24
`define ECB_IRQ_N 16
`define ECB_CHAN_IRQ_MASK 16'hCEF8
`define ECB_DMA_N 8
`endif

// [design/ecb_pkg.sv]
// types for the expansion channel bus control
package ecb_pkg;
  typedef enum logic [2:0]
  {
    ECB_IDLE = 3'b000,
    ECB_ADDR = 3'b001,
    ECB_CMD = 3'b011,
    ECB_WAIT = 3'b010,
    ECB_END = 3'b110
  } ecb_state_t;
  typedef enum logic [1:0]
  {
    ECB_OP_MEMRD = 2'b00,
    ECB_OP_MEMWR = 2'b01,
    ECB_OP_IORD = 2'b10,
    ECB_OP_IOWR = 2'b11
  } ecb_op_t;
endpackage : ecb_pkg

// [design/ecb_if.sv]
// channel wires between the board and one adapter
interface ecb_if;
  logic [23:0] addr;
  logic [15:0] dataBoard;
  logic [15:0] dataAdapter;
  logic dataAdapterOe;
  logic addressLatchStrobe;
  logic dmaAddressOwnership;
  logic memReadStrobeN;
  logic memWriteStrobeN;
  logic lowMegReadStrobeN;
  logic lowMegWriteStrobeN;
  logic ioReadStrobeN;
  logic ioWriteStrobeN;
  logic highByteEnableN;
  logic channelReady;
  logic channelCheckErrorN;
  logic wideMemorySelectN;
  logic wideIoSelectN;
  logic noWaitRequestN;
  logic [15:0] interruptRequestLines;
  logic [7:0] dmaRequestLine;
  logic [7:0] dmaGrantN;
  logic transferEndPulse;
  logic refreshBoardN;
  logic refreshAdapterN;
  logic masterTakeN;
  logic boardDriveOe;
  logic [23:0] addrAdapter;
  logic memReadAdapterN;
  logic memWriteAdapterN;
  logic adapterDriveOe;
  modport board
  (
    output addr, dataBoard, addressLatchStrobe, dmaAddressOwnership,
    output memReadStrobeN, memWriteStrobeN, lowMegReadStrobeN,
    output lowMegWriteStrobeN, ioReadStrobeN, ioWriteStrobeN,
    output highByteEnableN, dmaGrantN, transferEndPulse, refreshBoardN,
    output boardDriveOe,
    input dataAdapter, dataAdapterOe, channelReady, channelCheckErrorN,
    input wideMemorySelectN, wideIoSelectN, noWaitRequestN,
    input interruptRequestLines, dmaRequestLine, refreshAdapterN,
    input masterTakeN, addrAdapter, memReadAdapterN, memWriteAdapterN,
    input adapterDriveOe
  );
  modport adapter
  (
    input addr, dataBoard, addressLatchStrobe, dmaAddressOwnership,
    input memReadStrobeN, memWriteStrobeN, lowMegReadStrobeN,
    input lowMegWriteStrobeN, ioReadStrobeN, ioWriteStrobeN,
    input highByteEnableN, dmaGrantN, transferEndPulse, refreshBoardN,
    input boardDriveOe,
    output dataAdapter, dataAdapterOe, channelReady, channelCheckErrorN,
    output wideMemorySelectN, wideIoSelectN, noWaitRequestN,
    output interruptRequestLines, dmaRequestLine, refreshAdapterN,
    output masterTakeN, addrAdapter, memReadAdapterN, memWriteAdapterN,
    output adapterDriveOe
  );
endinterface : ecb_if

// [design/ecb_board.sv]
// system board end of the expansion channel
`include "ecb_regs.svh"
module ecb_board
  import ecb_pkg::*;
#(
  parameter int MASTER_MAX_CYC = `ECB_MASTER_MAX_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // channel
  ecb_if.board bus,
  // cycle request
  input wire logic reqValid,
  input wire ecb_op_t reqOp,
  input wire logic [23:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic reqHigh,
  input wire logic reqDma,
  // cycle answer
  output logic doneValid,
  output logic [15:0] doneData,
  output logic doneWide,
  output logic busyOut,
  // dma side
  input wire logic [7:0] dmaGrantIn,
  input wire logic dmaTerminal,
  input wire logic refreshReq,
  // interrupts, errors, refresh and takeover status
  output logic [3:0] irqVector,
  output logic irqValid,
  input wire logic irqAck,
  output logic nmiOut,
  output logic refreshSeen,
  output logic masterActive,
  output logic masterOverrun
);
  ecb_state_t state_reg;
  ecb_op_t op_reg;
  logic [3:0] waitCnt_reg;
  logic wide_reg;
  logic [15:0] irqLast_reg;
  logic [15:0] irqPend_reg;
  logic [1:0] chkCnt_reg;
  logic [15:0] masterCnt_reg;
  logic cmd_reg;
  logic isMem;
  logic takeover;
  assign isMem = (op_reg == ECB_OP_MEMRD) || (op_reg == ECB_OP_MEMWR);
  assign takeover = ~bus.masterTakeN;

  function automatic logic [3:0] irqPick(input logic [15:0] p);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 7; i >= 3; i--) if (p[i]) v = 4'(i);
    for (int i = 15; i >= 14; i--) if (p[i]) v = 4'(i);
    for (int i = 11; i >= 9; i--) if (p[i]) v = 4'(i);
    return v;
  endfunction : irqPick

  // bus cycle sequencer
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ECB_IDLE;
      op_reg <= ECB_OP_MEMRD;
      waitCnt_reg <= 4'h0;
      wide_reg <= 1'b0;
      doneValid <= 1'b0;
      doneData <= 16'h0000;
      doneWide <= 1'b0;
      busyOut <= 1'b0;
      bus.addr <= 24'h000000;
      bus.dataBoard <= 16'h0000;
      bus.addressLatchStrobe <= 1'b0;
      bus.dmaAddressOwnership <= 1'b0;
      bus.highByteEnableN <= 1'b1;
      cmd_reg <= 1'b0;
    end
    else
    begin
      doneValid <= 1'b0;
      unique case (state_reg)
        ECB_IDLE:
        begin
          bus.addressLatchStrobe <= 1'b0;
          bus.dmaAddressOwnership <= 1'b0;
          if (reqValid && !takeover)
          begin
            state_reg <= ECB_ADDR;
            op_reg <= reqOp;
            bus.addr <= reqAddr;
            bus.dataBoard <= reqData;
            bus.addressLatchStrobe <= 1'b1;
            bus.dmaAddressOwnership <= reqDma;
            bus.highByteEnableN <= ~reqHigh;
            busyOut <= 1'b1;
          end
        end
        ECB_ADDR:
        begin
          bus.addressLatchStrobe <= bus.dmaAddressOwnership;
          state_reg <= ECB_CMD;
          cmd_reg <= 1'b1;
          if (isMem)
            wide_reg <= ~bus.wideMemorySelectN;
          else
            wide_reg <= ~bus.wideIoSelectN;
          waitCnt_reg <= isMem && !bus.wideMemorySelectN ? 4'(`ECB_WIDE_WAIT)
                       : !isMem && !bus.wideIoSelectN ? 4'(`ECB_WIDE_WAIT)
                       : 4'(`ECB_BASE_WAIT);
        end
        ECB_CMD:
        begin
          if (!bus.noWaitRequestN)
            state_reg <= ECB_END;
          else if (!bus.channelReady)
            state_reg <= ECB_CMD;
          else if (waitCnt_reg <= 4'h1)
            state_reg <= ECB_END;
          else
            waitCnt_reg <= waitCnt_reg - 4'h1;
        end
        ECB_END:
        begin
          cmd_reg <= 1'b0;
          doneValid <= 1'b1;
          doneWide <= wide_reg;
          doneData <= bus.dataAdapter;
          busyOut <= 1'b0;
          bus.highByteEnableN <= 1'b1;
          state_reg <= ECB_IDLE;
        end
        default:
          state_reg <= ECB_IDLE;
      endcase
    end
  end

  // memory commands and low-meg gating start on the falling edge
  always_ff @(negedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.memReadStrobeN <= 1'b1;
      bus.memWriteStrobeN <= 1'b1;
      bus.lowMegReadStrobeN <= 1'b1;
      bus.lowMegWriteStrobeN <= 1'b1;
    end
    else if (takeover)
    begin
      bus.memReadStrobeN <= bus.memReadAdapterN;
      bus.memWriteStrobeN <= bus.memWriteAdapterN;
      bus.lowMegReadStrobeN <= bus.memReadAdapterN |
        (|bus.addrAdapter[23:`ECB_LOWMEG_BIT]);
      bus.lowMegWriteStrobeN <= bus.memWriteAdapterN |
        (|bus.addrAdapter[23:`ECB_LOWMEG_BIT]);
    end
    else
    begin
      bus.memReadStrobeN <= ~(cmd_reg && op_reg == ECB_OP_MEMRD);
      bus.memWriteStrobeN <= ~(cmd_reg && op_reg == ECB_OP_MEMWR);
      bus.lowMegReadStrobeN <= ~(cmd_reg && op_reg == ECB_OP_MEMRD &&
        !(|bus.addr[23:`ECB_LOWMEG_BIT]));
      bus.lowMegWriteStrobeN <= ~(cmd_reg && op_reg == ECB_OP_MEMWR &&
        !(|bus.addr[23:`ECB_LOWMEG_BIT]));
    end
  end

  // io command strobes, drive enable, refresh
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.ioReadStrobeN <= 1'b1;
      bus.ioWriteStrobeN <= 1'b1;
      bus.boardDriveOe <= 1'b1;
      refreshSeen <= 1'b0;
      bus.refreshBoardN <= 1'b1;
    end
    else
    begin
      bus.boardDriveOe <= ~takeover;
      bus.refreshBoardN <= ~refreshReq;
      refreshSeen <= ~bus.refreshBoardN | ~bus.refreshAdapterN;
      if (takeover)
      begin
        bus.ioReadStrobeN <= 1'b1;
        bus.ioWriteStrobeN <= 1'b1;
      end
      else
      begin
        bus.ioReadStrobeN <= ~(cmd_reg && op_reg == ECB_OP_IORD);
        bus.ioWriteStrobeN <= ~(cmd_reg && op_reg == ECB_OP_IOWR);
      end
    end
  end

  // interrupt edge capture and priority
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqLast_reg <= 16'h0000;
      irqPend_reg <= 16'h0000;
      irqVector <= 4'h0;
      irqValid <= 1'b0;
    end
    else
    begin
      irqLast_reg <= bus.interruptRequestLines & 16'(`ECB_CHAN_IRQ_MASK);
      for (int i = 0; i < 16; i++)
      begin
        if (bus.interruptRequestLines[i] && !irqLast_reg[i] &&
            ((16'(`ECB_CHAN_IRQ_MASK) >> i) & 16'h1) != 16'h0)
          irqPend_reg[i] <= 1'b1;
        else if (irqAck && irqValid && irqVector == 4'(i))
          irqPend_reg[i] <= 1'b0;
      end
      irqValid <= |irqPend_reg;
      irqVector <= irqPick(irqPend_reg);
    end
  end

  // channel check, takeover watch, dma grant and terminal count
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      chkCnt_reg <= 2'b00;
      nmiOut <= 1'b0;
      masterCnt_reg <= 16'h0000;
      masterActive <= 1'b0;
      masterOverrun <= 1'b0;
      bus.dmaGrantN <= 8'hFF;
      bus.transferEndPulse <= 1'b0;
    end
    else
    begin
      if (bus.channelCheckErrorN)
        chkCnt_reg <= 2'b00;
      else if (chkCnt_reg != 2'b11)
        chkCnt_reg <= chkCnt_reg + 2'b01;
      nmiOut <= !bus.channelCheckErrorN &&
        chkCnt_reg >= 2'(`ECB_CHK_MIN_CYC - 1);
      masterActive <= takeover;
      if (!takeover)
        masterCnt_reg <= 16'h0000;
      else if (masterCnt_reg != 16'hFFFF)
        masterCnt_reg <= masterCnt_reg + 16'h0001;
      masterOverrun <= takeover &&
        masterCnt_reg >= 16'(MASTER_MAX_CYC);
      bus.dmaGrantN <= ~dmaGrantIn;
      bus.transferEndPulse <= dmaTerminal;
    end
  end
endmodule : ecb_board

// [design/ecb_adapter.sv]
// adapter end of the expansion channel
`include "ecb_regs.svh"
module ecb_adapter
  import ecb_pkg::*;
#(
  parameter int READY_WAIT = 2
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // channel
  ecb_if.adapter bus,
  // decode settings
  input wire logic [23:0] baseAddr,
  input wire logic [23:0] maskAddr,
  input wire logic isIo,
  input wire logic isWide,
  input wire logic useNoWait,
  input wire logic slowMode,
  // user side
  input wire logic [15:0] readData,
  output logic [15:0] writeData,
  output logic writeValid,
  input wire logic [15:0] irqRaise,
  input wire logic errorReq,
  input wire logic [7:0] masterReq,
  input wire logic masterDone,
  input wire logic [23:0] masterAddr,
  input wire logic masterWrite,
  output logic masterOwned
);
  logic hit;
  logic cmdActive;
  logic [4:0] rdyCnt_reg;
  logic [1:0] errCnt_reg;
  logic [1:0] takeCnt_reg;
  logic [15:0] irqHold_reg;
  assign hit = ((bus.addr & maskAddr) == (baseAddr & maskAddr)) &&
    !bus.dmaAddressOwnership;
  assign cmdActive = isIo ? (!bus.ioReadStrobeN || !bus.ioWriteStrobeN)
                          : (!bus.memReadStrobeN || !bus.memWriteStrobeN);

  // data, ready, selects
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.dataAdapter <= 16'h0000;
      bus.dataAdapterOe <= 1'b0;
      bus.channelReady <= 1'b1;
      bus.wideMemorySelectN <= 1'b1;
      bus.wideIoSelectN <= 1'b1;
      bus.noWaitRequestN <= 1'b1;
      rdyCnt_reg <= 5'h00;
      writeData <= 16'h0000;
      writeValid <= 1'b0;
    end
    else
    begin
      writeValid <= 1'b0;
      bus.wideMemorySelectN <= ~(isWide && !isIo &&
        ((bus.addr[23:17] & maskAddr[23:17]) ==
         (baseAddr[23:17] & maskAddr[23:17])));
      bus.wideIoSelectN <= ~(isWide && isIo && hit);
      bus.noWaitRequestN <= ~(useNoWait && hit && cmdActive);
      bus.dataAdapterOe <= hit && (isIo ? !bus.ioReadStrobeN
                                         : !bus.memReadStrobeN);
      bus.dataAdapter <= readData;
      if (hit && cmdActive && slowMode &&
          rdyCnt_reg < 5'(READY_WAIT) &&
          rdyCnt_reg < 5'(`ECB_RDY_MAX_CYC))
      begin
        bus.channelReady <= 1'b0;
        rdyCnt_reg <= rdyCnt_reg + 5'h01;
      end
      else
        bus.channelReady <= 1'b1;
      if (!cmdActive)
        rdyCnt_reg <= 5'h00;
      if (hit && (isIo ? !bus.ioWriteStrobeN : !bus.memWriteStrobeN))
      begin
        writeData <= bus.dataBoard;
        writeValid <= 1'b1;
      end
    end
  end

  // error, interrupt, bus takeover
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      errCnt_reg <= 2'b00;
      bus.channelCheckErrorN <= 1'b1;
      irqHold_reg <= 16'h0000;
      bus.interruptRequestLines <= 16'h0000;
      bus.dmaRequestLine <= 8'h00;
      bus.masterTakeN <= 1'b1;
      takeCnt_reg <= 2'b00;
      bus.refreshAdapterN <= 1'b1;
      bus.addrAdapter <= 24'h000000;
      bus.memReadAdapterN <= 1'b1;
      bus.memWriteAdapterN <= 1'b1;
      bus.adapterDriveOe <= 1'b0;
      masterOwned <= 1'b0;
    end
    else
    begin
      if (errorReq)
        errCnt_reg <= 2'(`ECB_CHK_MIN_CYC);
      else if (errCnt_reg != 2'b00)
        errCnt_reg <= errCnt_reg - 2'b01;
      bus.channelCheckErrorN <= ~(errorReq || errCnt_reg > 2'b01);
      irqHold_reg <= (irqHold_reg | irqRaise) & 16'(`ECB_CHAN_IRQ_MASK);
      bus.interruptRequestLines <= irqHold_reg;
      if (masterDone)
      begin
        irqHold_reg <= 16'h0000;
        bus.dmaRequestLine <= 8'h00;
        bus.masterTakeN <= 1'b1;
        takeCnt_reg <= 2'b00;
        bus.adapterDriveOe <= 1'b0;
        bus.memReadAdapterN <= 1'b1;
        bus.memWriteAdapterN <= 1'b1;
        masterOwned <= 1'b0;
      end
      else
      begin
        bus.dmaRequestLine <= masterReq & ~(~bus.dmaGrantN);
        if ((|masterReq) && (|(~bus.dmaGrantN & masterReq)))
          bus.masterTakeN <= 1'b0;
        if (!bus.masterTakeN && takeCnt_reg != 2'b11)
          takeCnt_reg <= takeCnt_reg + 2'b01;
        bus.adapterDriveOe <= !bus.masterTakeN && takeCnt_reg != 2'b00;
        bus.addrAdapter <= masterAddr;
        masterOwned <= !bus.masterTakeN;
        bus.memReadAdapterN <= ~(takeCnt_reg >= 2'b10 && !masterWrite);
        bus.memWriteAdapterN <= ~(takeCnt_reg >= 2'b10 && masterWrite);
      end
    end
  end
endmodule : ecb_adapter

// [bench/ecb_bus_checker.sv]
// assertions on the channel wires between board and adapter
`include "ecb_regs.svh"
module ecb_bus_checker
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // board side
  input wire logic [23:0] addr,
  input wire logic addressLatchStrobe,
  input wire logic dmaAddressOwnership,
  input wire logic memReadStrobeN,
  input wire logic memWriteStrobeN,
  input wire logic lowMegReadStrobeN,
  input wire logic lowMegWriteStrobeN,
  input wire logic ioReadStrobeN,
  input wire logic ioWriteStrobeN,
  input wire logic boardDriveOe,
  // adapter side
  input wire logic channelReady,
  input wire logic masterTakeN,
  input wire logic [23:0] addrAdapter,
  input wire logic memReadAdapterN,
  input wire logic memWriteAdapterN,
  input wire logic adapterDriveOe
);
  logic [4:0] rdyLowCnt_reg;
  logic anyCmd;
  logic lowMeg;
  assign anyCmd = !(memReadStrobeN && memWriteStrobeN && ioReadStrobeN
    && ioWriteStrobeN);
  assign lowMeg = addr[23:20] == 4'h0;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // consecutive not-ready cycles
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdyLowCnt_reg <= 5'h00;
    else if (channelReady)
      rdyLowCnt_reg <= 5'h00;
    else if (rdyLowCnt_reg != 5'h1F)
      rdyLowCnt_reg <= rdyLowCnt_reg + 5'h01;
  end
  a_lowmeg_read: assert property (
    boardDriveOe |-> (!lowMegReadStrobeN == (!memReadStrobeN && lowMeg)))
    else $error("low meg read strobe wrong");
  a_lowmeg_write: assert property (
    boardDriveOe |-> (!lowMegWriteStrobeN == (!memWriteStrobeN && lowMeg)))
    else $error("low meg write strobe wrong");
  a_one_command: assert property (
    boardDriveOe && !dmaAddressOwnership |-> $onehot0({!memReadStrobeN,
    !memWriteStrobeN, !ioReadStrobeN, !ioWriteStrobeN}))
    else $error("two commands at once");
  a_ready_stretch: assert property (
    anyCmd && !channelReady |=> anyCmd)
    else $error("cycle ended while not ready");
  a_ready_bound: assert property (
    rdyLowCnt_reg <= `ECB_RDY_MAX_CYC)
    else $error("ready held low too long");
  a_ready_on_cmd: assert property (
    $fell(channelReady) |-> anyCmd || $past(anyCmd))
    else $error("ready dropped without command");
  a_master_floats: assert property (
    !masterTakeN [*2] |-> !boardDriveOe)
    else $error("board drives during takeover");
  a_master_cmd_wait: assert property (
    $fell(masterTakeN) |-> (memReadAdapterN && memWriteAdapterN) [*2])
    else $error("master command too early");
  a_master_addr_first: assert property (
    $fell(memReadAdapterN) || $fell(memWriteAdapterN) |->
    $stable(addrAdapter) && $past(adapterDriveOe))
    else $error("master address not held first");
  a_dma_latch_high: assert property (
    dmaAddressOwnership && $past(dmaAddressOwnership) |-> addressLatchStrobe)
    else $error("latch strobe low during dma");
endmodule : ecb_bus_checker

// [bench/tb.sv]
// self-checking bench for the board and adapter ends together
module tb
  import ecb_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int READY_WAIT = 4;
  logic mclk, rstn, reqValid, reqHigh, reqDma, irqAck, dmaTerminal, refreshReq;
  logic isIo, isWide, useNoWait, slowMode, errorReq, masterDone;
  logic doneValid, doneWide, busyOut, irqValid, nmiOut, refreshSeen;
  logic masterActive, masterOverrun, writeValid, masterOwned;
  logic sawLow, sawMem, sawHigh, sawWrite, sawDone;
  ecb_op_t reqOp;
  logic [23:0] reqAddr, baseAddr, maskAddr;
  logic [15:0] reqData, irqRaise, writeData, doneData, gotWrite;
  logic [7:0] dmaGrantIn, masterReq;
  logic [3:0] irqVector;
  int failures = 0;
  int num_checks = 0;
  ecb_if bus();
  ecb_board #(.MASTER_MAX_CYC(20)) u_ecb_board
  (
    .mclk(mclk), .rstn(rstn), .bus(bus), .reqValid(reqValid), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqData(reqData), .reqHigh(reqHigh), .reqDma(reqDma),
    .doneValid(doneValid), .doneData(doneData), .doneWide(doneWide),
    .busyOut(busyOut), .dmaGrantIn(dmaGrantIn), .dmaTerminal(dmaTerminal),
    .refreshReq(refreshReq), .irqVector(irqVector), .irqValid(irqValid),
    .irqAck(irqAck), .nmiOut(nmiOut), .refreshSeen(refreshSeen),
    .masterActive(masterActive), .masterOverrun(masterOverrun)
  );
  ecb_adapter #(.READY_WAIT(READY_WAIT)) u_ecb_adapter
  (
    .mclk(mclk), .rstn(rstn), .bus(bus), .baseAddr(baseAddr),
    .maskAddr(maskAddr), .isIo(isIo), .isWide(isWide), .useNoWait(useNoWait),
    .slowMode(slowMode), .readData(16'hA5C3), .writeData(writeData),
    .writeValid(writeValid), .irqRaise(irqRaise), .errorReq(errorReq),
    .masterReq(masterReq), .masterDone(masterDone),
    .masterAddr(24'h012340), .masterWrite(1'b0), .masterOwned(masterOwned)
  );
  ecb_bus_checker u_ecb_bus_checker
  (
    .mclk(mclk), .rstn(rstn), .addr(bus.addr),
    .addressLatchStrobe(bus.addressLatchStrobe),
    .dmaAddressOwnership(bus.dmaAddressOwnership),
    .memReadStrobeN(bus.memReadStrobeN), .memWriteStrobeN(bus.memWriteStrobeN),
    .lowMegReadStrobeN(bus.lowMegReadStrobeN),
    .lowMegWriteStrobeN(bus.lowMegWriteStrobeN),
    .ioReadStrobeN(bus.ioReadStrobeN), .ioWriteStrobeN(bus.ioWriteStrobeN),
    .boardDriveOe(bus.boardDriveOe), .channelReady(bus.channelReady),
    .masterTakeN(bus.masterTakeN), .addrAdapter(bus.addrAdapter),
    .memReadAdapterN(bus.memReadAdapterN),
    .memWriteAdapterN(bus.memWriteAdapterN),
    .adapterDriveOe(bus.adapterDriveOe)
  );
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // what the wires showed during a cycle
  always @(posedge mclk)
  begin
    sawLow <= sawLow | !bus.lowMegReadStrobeN | !bus.lowMegWriteStrobeN;
    sawMem <= sawMem | !bus.memReadStrobeN | !bus.memWriteStrobeN;
    sawHigh <= sawHigh | !bus.highByteEnableN;
    sawWrite <= sawWrite | writeValid;
    sawDone <= sawDone | doneValid;
    if (writeValid === 1'b1)
      gotWrite <= writeData;
  end
  // 8-bit memory commands start on the falling clock edge
  always @(negedge bus.memReadStrobeN or negedge bus.memWriteStrobeN)
    if (rstn === 1'b1 && bus.boardDriveOe === 1'b1 && isWide === 1'b0)
      check("memCmdEdge", 24'h0, {23'h0, mclk});
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic limit(input int n, input int lim);
    if (n >= lim)
    begin
      failures++;
      $display("mismatch wait expected %0d seen %0d", lim, n);
      stop_test();
    end
  endtask : limit
  task automatic run_cycle(input ecb_op_t op, input logic [23:0] a,
    input logic [15:0] d, input logic hi, input logic dma, output int c);
    @(negedge mclk);
    {reqValid, reqOp, reqAddr, reqData, reqHigh, reqDma} = {1'b1, op, a, d,
      hi, dma};
    {sawLow, sawMem, sawHigh, sawWrite} = 4'h0;
    @(negedge mclk);
    reqValid = 1'b0;
    for (c = 1; c < 60 && doneValid !== 1'b1; c++) @(negedge mclk);
    limit(c, 60);
  endtask : run_cycle
  task automatic t_io();
    int c;
    {isIo, isWide, baseAddr, maskAddr} = {2'b11, 24'h000300, 24'hFFFFF0};
    run_cycle(ECB_OP_IOWR, 24'h000302, 16'h5A3C, 1'b1, 1'b0, c);
    check("writeValid", 24'h1, {23'h0, sawWrite});
    check("writeData", 24'h5A3C, {8'h0, gotWrite});
    check("highByte", 24'h1, {23'h0, sawHigh});
    run_cycle(ECB_OP_IORD, 24'h000304, 16'h0000, 1'b1, 1'b0, c);
    check("doneData", 24'hA5C3, {8'h0, doneData});
    check("ioWide", 24'h1, {23'h0, doneWide});
    run_cycle(ECB_OP_IOWR, 24'h000302, 16'h1111, 1'b1, 1'b1, c);
    check("dmaWrite", 24'h0, {23'h0, sawWrite});
  endtask : t_io
  task automatic t_ready();
    int a, b;
    {isWide, slowMode} = 2'b00;
    run_cycle(ECB_OP_IORD, 24'h000306, 16'h0000, 1'b0, 1'b0, a);
    check("highByteOff", 24'h0, {23'h0, sawHigh});
    slowMode = 1'b1;
    run_cycle(ECB_OP_IORD, 24'h000306, 16'h0000, 1'b0, 1'b0, b);
    slowMode = 1'b0;
    check("waitStates", 24'(READY_WAIT), 24'(b - a));
  endtask : t_ready
  task automatic t_mem();
    int a, b;
    {isIo, isWide, useNoWait, baseAddr, maskAddr} = '0;
    run_cycle(ECB_OP_MEMRD, 24'h0F0000, 16'h0000, 1'b0, 1'b0, a);
    check("lowMegIn", 24'h1, {23'h0, sawLow});
    run_cycle(ECB_OP_MEMRD, 24'h200000, 16'h0000, 1'b0, 1'b0, b);
    check("lowMegOut", 24'h0, {23'h0, sawLow});
    check("memStrobe", 24'h1, {23'h0, sawMem});
    run_cycle(ECB_OP_MEMWR, 24'h0F0010, 16'h00C3, 1'b0, 1'b0, b);
    check("lowMegWr", 24'h1, {23'h0, sawLow});
    isWide = 1'b1;
    run_cycle(ECB_OP_MEMRD, 24'h020000, 16'h0000, 1'b1, 1'b0, b);
    check("memWide", 24'h1, {23'h0, doneWide});
    isWide = 1'b0;
    useNoWait = 1'b1;
    run_cycle(ECB_OP_MEMRD, 24'h020000, 16'h0000, 1'b1, 1'b0, b);
    useNoWait = 1'b0;
    check("noWaitShorter", 24'h1, {23'h0, b < a});
  endtask : t_mem
  task automatic t_irq();
    int n, i;
    int order[3] = '{9, 3, 7};
    irqRaise = 16'h3100;
    repeat (10) @(negedge mclk);
    check("irqMasked", 24'h0, {23'h0, irqValid});
    irqRaise = 16'h3388;
    for (i = 0; i < 3; i++)
    begin
      repeat (2) @(negedge mclk);
      for (n = 0; n < 20 && irqValid !== 1'b1; n++) @(negedge mclk);
      limit(n, 20);
      check("irqVector", 24'(order[i]), {20'h0, irqVector});
      irqAck = 1'b1;
      @(negedge mclk);
      irqAck = 1'b0;
    end
    repeat (5) @(negedge mclk);
    check("irqEdgeOnly", 24'h0, {23'h0, irqValid});
  endtask : t_irq
  task automatic t_misc();
    int n;
    {dmaGrantIn, dmaTerminal} = {8'h04, 1'b1};
    @(negedge mclk);
    dmaTerminal = 1'b0;
    check("tcPulse", 24'h1, {23'h0, bus.transferEndPulse});
    check("grantN", 24'hFB, {16'h0, bus.dmaGrantN});
    @(negedge mclk);
    check("tcEnd", 24'h0, {23'h0, bus.transferEndPulse});
    {dmaGrantIn, errorReq} = {8'h00, 1'b1};
    @(negedge mclk);
    errorReq = 1'b0;
    for (n = 0; n < 20 && nmiOut !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    refreshReq = 1'b1;
    for (n = 0; n < 20 && refreshSeen !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    refreshReq = 1'b0;
  endtask : t_misc
  task automatic t_master();
    int n;
    masterReq = 8'h20;
    for (n = 0; n < 20 && bus.dmaRequestLine[5] !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    dmaGrantIn = 8'h20;
    for (n = 0; n < 20 && masterActive !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    {sawDone, reqValid} = 2'b01;
    repeat (6) @(negedge mclk);
    reqValid = 1'b0;
    check("refused", 24'h0, {23'h0, sawDone});
    check("boardFloat", 24'h0, {23'h0, bus.boardDriveOe});
    check("owned", 24'h1, {23'h0, masterOwned});
    repeat (24) @(negedge mclk);
    check("overrun", 24'h1, {23'h0, masterOverrun});
    masterDone = 1'b1;
    for (n = 0; n < 20 && masterActive !== 1'b0; n++) @(negedge mclk);
    limit(n, 20);
    {masterDone, masterReq, dmaGrantIn} = '0;
  endtask : t_master
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("mismatch watchdog expected finish seen hang");
    stop_test();
  end
  initial
  begin
    rstn = 1'b0;
    {reqValid, reqHigh, reqDma, irqAck, dmaTerminal, refreshReq} = '0;
    {isIo, isWide, useNoWait, slowMode, errorReq, masterDone} = '0;
    {reqAddr, baseAddr, maskAddr, reqData, irqRaise} = '0;
    {dmaGrantIn, masterReq} = '0;
    reqOp = ECB_OP_MEMRD;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    t_io();
    t_ready();
    t_mem();
    t_irq();
    t_misc();
    t_master();
    stop_test();
  end
endmodule : tb
